// ==== logic/flash_opt_pkg.sv ====
package flash_opt_pkg;
	localparam logic [14:0] OPT_ADDR       = 15'h3FFF;
	localparam logic [15:0] OPT_ALIAS_ADDR = 16'hFFFF;
	localparam logic [7:0]  OPT_RESET_VAL  = 8'h00;
	localparam logic [7:0]  ERASED_VAL     = 8'h00;
	localparam logic [7:0]  SECURED_VAL    = 8'hFF;
	localparam int          BIT_SECURE     = 5;
	localparam int          BIT_WD_OFF     = 2;
	localparam int          BIT_HALT_OFF   = 1;
	localparam int          BIT_FLASH_BOOT = 0;
	localparam logic [7:0]  RSVD_MASK      = 8'hD8;
	localparam int          PAGE_BYTES     = 64;
	localparam int          MEM_BYTES      = 8192;
	localparam int          SAMPLE_CYCLES  = 2;

	typedef enum logic [1:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_PAGE_ERASE,
		CMD_MASS_ERASE
	} cmd_t;
endpackage

// ==== logic/flash_req_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface flash_req_if;
	logic        valid;
	logic [1:0]  cmd;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        user_isp;
	logic        grant;
	logic        refused;

	modport gate (input valid, cmd, addr, user_isp, output grant, refused);
	modport core (output valid, cmd, addr, wdata, user_isp, input grant, refused);
endinterface
`default_nettype wire

// ==== logic/flash_access_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_access_gate (
	input  wire logic secured,
	input  wire logic prog_mode,
	input  wire logic opt_locked,
	flash_req_if.gate req
);
	// ************************************************************
	// Decision for one flash request.
	// ************************************************************
	logic is_opt;
	logic ok;

	always_comb begin
		is_opt = (req.addr[14:0] == flash_opt_pkg::OPT_ADDR) ||
			(req.addr == flash_opt_pkg::OPT_ALIAS_ADDR);
		ok = 1'b0;
		case (req.cmd)
			flash_opt_pkg::CMD_READ:       ok = 1'b1;
			flash_opt_pkg::CMD_WRITE:      ok = !(is_opt && opt_locked) &&
				(req.user_isp || (!secured && prog_mode));
			flash_opt_pkg::CMD_PAGE_ERASE: ok = req.user_isp || !secured;
			flash_opt_pkg::CMD_MASS_ERASE: ok = 1'b1;
			default:                       ok = 1'b0;
		endcase
		req.grant   = req.valid && ok;
		req.refused = req.valid && !ok;
	end
endmodule // flash_access_gate
`default_nettype wire

// ==== logic/flash_option_security.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Option byte at 0x3FFF selects four features.
// - Secure bit blocks external read and write.
// - Watchdog bit selects pin as watchdog or I/O.
// - Halt-off bit ignores halt requests.
// - Boot bit selects flash or boot ROM.
// - Option writes only in programming modes.
// - Unprogrammed option byte reads zero.
// - Secured reads return FF except option.
// - Secured blocks writes to flash and option.
// - Secured blocks page erase.
// - Alias FFFF always returns option byte.
// - Mass erase always allowed.
// - Secure bit cleared only by mass erase or the user path.
// - Option written once until last page erased.
// - Unsecured allows external reads.
module flash_option_security #(
	parameter int MEM_BYTES  = flash_opt_pkg::MEM_BYTES,
	parameter int PAGE_BYTES = flash_opt_pkg::PAGE_BYTES
) (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        prog_mode,
	input  wire logic        req_valid,
	input  wire logic [1:0]  req_cmd,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	input  wire logic        req_user_isp,
	input  wire logic        halt_req,
	input  wire logic        wd_fault_n,
	input  wire logic        gpio_out,
	input  wire logic        gpio_oe,
	output logic             rsp_valid,
	output logic             rsp_refused,
	output logic [7:0]       rsp_rdata,
	output logic             halt_enter,
	output logic             boot_from_flash,
	output logic             watchdog_enabled,
	output logic             watchdog_out_pin_o,
	output logic             watchdog_out_pin_oe,
	output logic             watchdog_out_pin_pu
);
	// ************************************************************
	// Geometry.
	// ************************************************************
	// The array index is the low address bits and a page is a run of
	// index values that share their upper bits, so both sizes must be
	// powers of two and the array must hold more than one page.
	localparam int AW = $clog2(MEM_BYTES);
	localparam int PW = $clog2(PAGE_BYTES);

	if (PAGE_BYTES < 1 || MEM_BYTES <= PAGE_BYTES || MEM_BYTES > 32768 ||
			(1 << AW) != MEM_BYTES || (1 << PW) != PAGE_BYTES) begin : g_bad_geometry
		$error("Unsupported flash geometry.");
	end

	// ************************************************************
	// Storage and state.
	// ************************************************************
	logic [7:0]          mem_r   [MEM_BYTES];
	logic [7:0]          mem_nxt [MEM_BYTES];
	// The option byte and its write lock are flash cells, so they keep
	// their value through reset and start from the blank state only at
	// power-up.
	logic [7:0]          opt_r      = flash_opt_pkg::OPT_RESET_VAL;
	logic [7:0]          opt_nxt;
	logic                opt_lock_r = 1'b0;
	logic                opt_lock_nxt;
	logic [7:0]          cfg_r, cfg_nxt;
	logic [1:0]          smp_r, smp_nxt;
	// The response registers answer the request of the previous cycle.
	logic                rv_r, rv_nxt, rf_r, rf_nxt;
	logic [7:0]          rd_r, rd_nxt;
	logic                halt_r, halt_nxt;
	logic                wden_r, wden_nxt;
	logic                wo_r, wo_nxt, woe_r, woe_nxt, wpu_r, wpu_nxt;

	// ************************************************************
	// Request decision.
	// ************************************************************
	// The gate judges each request in the cycle it arrives; the answer
	// is registered below and shows one cycle later.
	flash_req_if req ();
	assign req.valid    = req_valid;
	assign req.cmd      = req_cmd;
	assign req.addr     = req_addr;
	assign req.wdata    = req_wdata;
	assign req.user_isp = req_user_isp;

	flash_access_gate u_gate (
		.secured    (cfg_r[flash_opt_pkg::BIT_SECURE]),
		.prog_mode  (prog_mode),
		.opt_locked (opt_lock_r),
		.req        (req.gate)
	);

	// ************************************************************
	// Address decoding.
	// ************************************************************
	function automatic logic is_opt(input logic [15:0] a);
		is_opt = (a[14:0] == flash_opt_pkg::OPT_ADDR);
	endfunction

	function automatic logic is_alias(input logic [15:0] a);
		is_alias = (a == flash_opt_pkg::OPT_ALIAS_ADDR);
	endfunction

	// Page number of an array index.
	function automatic logic [AW-PW-1:0] page_of(input logic [AW-1:0] a);
		page_of = a[AW-1:PW];
	endfunction

	// The last page holds the option location, so erasing it frees the
	// option byte for one new write.
	function automatic logic is_last_page(input logic [AW-1:0] a);
		is_last_page = (page_of(a) == {(AW-PW){1'b1}});
	endfunction

	// ************************************************************
	// Flash array, option byte and access response.
	// ************************************************************
	always_comb begin
		logic [AW-1:0] idx;
		idx = req_addr[AW-1:0];
		mem_nxt      = mem_r;
		opt_nxt      = opt_r;
		opt_lock_nxt = opt_lock_r;
		rv_nxt       = req_valid;
		rf_nxt       = req.refused;
		// Only a granted read puts data on the response; all else is zero.
		rd_nxt       = 8'h00;
		if (req.grant) begin
			case (flash_opt_pkg::cmd_t'(req_cmd))
				flash_opt_pkg::CMD_READ: begin
					// The option byte answers at both of its addresses even
					// when the array is secured; the user path sees the array
					// as stored.
					if (is_alias(req_addr) || is_opt(req_addr))
						rd_nxt = opt_r;
					else if (cfg_r[flash_opt_pkg::BIT_SECURE] && !req_user_isp)
						rd_nxt = flash_opt_pkg::SECURED_VAL;
					else
						rd_nxt = mem_r[idx];
				end
				flash_opt_pkg::CMD_WRITE: begin
					// An accepted option write locks the byte until the last
					// page or the whole array is erased.
					if (is_opt(req_addr)) begin
						opt_nxt      = req.wdata;
						opt_lock_nxt = 1'b1;
					end else begin
						mem_nxt[idx] = req.wdata;
					end
				end
				flash_opt_pkg::CMD_PAGE_ERASE: begin
					for (int i = 0; i < MEM_BYTES; i++) begin
						if (page_of(AW'(i)) == page_of(idx))
							mem_nxt[i] = flash_opt_pkg::ERASED_VAL;
					end
					if (is_last_page(idx)) begin
						opt_nxt      = flash_opt_pkg::OPT_RESET_VAL;
						opt_lock_nxt = 1'b0;
						// A stored secure bit survives a page erase from the
						// programming port; only mass erase or the user path
						// may drop it.
						if (!req.user_isp)
							opt_nxt[flash_opt_pkg::BIT_SECURE] =
								opt_r[flash_opt_pkg::BIT_SECURE];
					end
				end
				// Mass erase is the programming port's one way back from a secured device: it
				// clears the array, the option byte and its lock.
				flash_opt_pkg::CMD_MASS_ERASE: begin
					for (int i = 0; i < MEM_BYTES; i++)
						mem_nxt[i] = flash_opt_pkg::ERASED_VAL;
					opt_nxt      = flash_opt_pkg::OPT_RESET_VAL;
					opt_lock_nxt = 1'b0;
				end
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Configuration capture after reset release.
	// ************************************************************
	// The option byte is copied once, one edge after reset release, and
	// then held until the next reset. A secure bit written in this session
	// therefore takes effect only after the next reset, which lets the
	// programmer verify the image before the device locks itself.
	always_comb begin
		smp_nxt = smp_r;
		cfg_nxt = cfg_r;
		if (smp_r != 2'(flash_opt_pkg::SAMPLE_CYCLES)) begin
			smp_nxt = smp_r + 2'd1;
			if (smp_r == 2'd0)
				cfg_nxt = opt_r & ~flash_opt_pkg::RSVD_MASK;
		end
	end

	// ************************************************************
	// Feature outputs.
	// ************************************************************
	// Nothing follows the configuration until it has been captured, so
	// the pin stays undriven and halt requests are dropped right after
	// reset.
	always_comb begin
		logic cap;
		cap      = (smp_r == 2'(flash_opt_pkg::SAMPLE_CYCLES));
		wden_nxt = !cfg_nxt[flash_opt_pkg::BIT_WD_OFF];
		halt_nxt = cap && halt_req && !cfg_r[flash_opt_pkg::BIT_HALT_OFF];
		if (cap && !cfg_r[flash_opt_pkg::BIT_WD_OFF]) begin
			// The watchdog only pulls low; the weak pull-up makes the high.
			wo_nxt  = 1'b0;
			woe_nxt = !wd_fault_n;
			wpu_nxt = 1'b1;
		end else begin
			wo_nxt  = gpio_out;
			woe_nxt = gpio_oe && cap;
			wpu_nxt = 1'b0;
		end
	end

	// ************************************************************
	// State registers.
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rv_r <= 1'b0;
			rf_r <= 1'b0;
			rd_r <= 8'h00;
		end else begin
			rv_r <= rv_nxt;
			rf_r <= rf_nxt;
			rd_r <= rd_nxt;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= flash_opt_pkg::OPT_RESET_VAL;
			smp_r <= 2'd0;
		end else begin
			cfg_r <= cfg_nxt;
			smp_r <= smp_nxt;
		end
	end

	// The watchdog-enable port follows the captured byte from the first
	// edge after reset release.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			halt_r <= 1'b0;
			wden_r <= 1'b0;
			wo_r   <= 1'b0;
			woe_r  <= 1'b0;
			wpu_r  <= 1'b0;
		end else begin
			halt_r <= halt_nxt;
			wden_r <= wden_nxt;
			wo_r   <= wo_nxt;
			woe_r  <= woe_nxt;
			wpu_r  <= wpu_nxt;
		end
	end

	// Flash cells survive reset, so the array and the option byte have
	// no reset term.
	always_ff @(posedge mclk) begin
		mem_r      <= mem_nxt;
		opt_r      <= opt_nxt;
		opt_lock_r <= opt_lock_nxt;
	end

	// ************************************************************
	// Ports.
	// ************************************************************
	// Every port is a plain copy of a register, so nothing combinational
	// reaches the pins of the device.
	always_comb begin
		rsp_valid           = rv_r;
		rsp_refused         = rf_r;
		rsp_rdata           = rd_r;
		halt_enter          = halt_r;
		boot_from_flash     = cfg_r[flash_opt_pkg::BIT_FLASH_BOOT];
		watchdog_enabled    = wden_r;
		watchdog_out_pin_o  = wo_r;
		watchdog_out_pin_oe = woe_r;
		watchdog_out_pin_pu = wpu_r;
	end
endmodule // flash_option_security
`default_nettype wire

// ==== test/opt_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Option byte and access gate checks.
// ****
module opt_sva (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        prog_mode,
	input wire logic        req_valid,
	input wire logic [1:0]  req_cmd,
	input wire logic [15:0] req_addr,
	input wire logic        req_user_isp,
	input wire logic        halt_req,
	input wire logic        rsp_valid,
	input wire logic        rsp_refused,
	input wire logic        halt_enter,
	input wire logic        boot_from_flash,
	input wire logic        watchdog_enabled
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_req(logic [1:0] c);
		req_valid && req_cmd == c;
	endsequence
	chk_rsp_next: assert property (req_valid |=> rsp_valid) else $error("no answer");
	chk_rsp_cause: assert property (rsp_valid |-> $past(req_valid)) else $error("stray answer");
	chk_ref_pair: assert property (rsp_refused |-> rsp_valid) else $error("bare refuse");
	chk_mass_ok: assert property (s_req(2'h3) |=> !rsp_refused) else $error("mass refused");
	chk_isp_erase: assert property (s_req(2'h2) and req_user_isp |=> !rsp_refused)
		else $error("isp erase refused");
	chk_run_write: assert property (s_req(2'h1) and !prog_mode && !req_user_isp
		|=> rsp_refused) else $error("run write taken");
	chk_alias_ok: assert property (s_req(2'h0) and req_addr == 16'hFFFF
		|=> !rsp_refused) else $error("alias refused");
	chk_halt_cause: assert property (halt_enter |-> $past(halt_req)) else $error("stray halt");
	chk_cfg_hold: assert property ($past(arst_n, 3) && $past(arst_n) |->
		$stable(boot_from_flash) && $stable(watchdog_enabled)) else $error("cfg moved");
endmodule // opt_sva
`default_nettype wire

// ==== test/prog_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module prog_host_model (
	input  wire logic  mclk,
	output logic       req_valid,
	output logic [1:0] req_cmd,
	output logic [15:0] req_addr,
	output logic [7:0] req_wdata,
	output logic       req_user_isp
);
	initial begin
		{req_valid, req_cmd, req_addr, req_wdata, req_user_isp} = '0;
	end
	task automatic send(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic isp);
		@(posedge mclk);
		#1;
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_user_isp = isp;
		if (c == 2'h1 && a == 16'h3FFF) req_wdata = (d & ~flash_opt_pkg::RSVD_MASK) | 8'h01;
		else req_wdata = d;
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		req_addr = ~req_addr;
		req_wdata = ~req_wdata;
	endtask
endmodule // prog_host_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	logic mclk = 0, arst_n = 0, prog_mode = 0, halt_req = 0;
	logic wd_fault_n = 1, gpio_out = 0, gpio_oe = 0;
	logic req_valid, req_user_isp, rsp_valid, rsp_refused, halt_enter;
	logic [1:0] req_cmd;
	logic [15:0] req_addr;
	logic [7:0] req_wdata, rsp_rdata, d;
	logic boot_from_flash, watchdog_enabled;
	logic watchdog_out_pin_o, watchdog_out_pin_oe, watchdog_out_pin_pu;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	int failures = 0, tests_run = 0, seed = 88, cyc = 0;
	logic [2:0] pin_in, pin_exp;
	logic pin_chk = 0, wd_exp = 1;
	flash_option_security flash_option_security_i (.*);
	prog_host_model prog_host_model_i (.*);
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) begin
		#1 {gpio_out, gpio_oe, wd_fault_n} = 3'($random(seed));
		cyc++;
		if (cyc == 2000) begin
			failures++;
			tally_and_finish();
		end
	end
	always @(negedge mclk) if (rsp_valid === 1'b1) begin
		e = exp_q.pop_front();
		`CHK({rsp_refused, rsp_rdata}, e)
	end
	always @(posedge mclk) pin_in <= {gpio_out, gpio_oe, wd_fault_n};
	always @(negedge mclk) if (pin_chk) begin
		pin_exp = wd_exp ? {1'b0, !pin_in[0], 1'b1} : {pin_in[2:1], 1'b0};
		`CHK({watchdog_out_pin_o, watchdog_out_pin_oe, watchdog_out_pin_pu}, pin_exp)
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] dv,
		input logic isp, input logic rf, input logic [7:0] rd);
		exp_q.push_back({rf, rd});
		prog_host_model_i.send(c, a, dv, isp);
	endtask
	task automatic rst();
		pin_chk = 0;
		@(negedge mclk);
		@(posedge mclk);
		#1 arst_n = 0;
		repeat (5) @(posedge mclk);
		#1 arst_n = 1;
		repeat (3) @(posedge mclk);
		#1 pin_chk = 1;
	endtask
	task automatic halt_chk(input logic x);
		@(posedge mclk);
		#1 halt_req = 1;
		@(posedge mclk);
		#1 halt_req = 0;
		@(negedge mclk);
		`CHK(halt_enter, x)
	endtask
	initial begin
		d = 8'($random(seed));
		rst();
		`CHK(boot_from_flash, 1'b0)
		`CHK(watchdog_enabled, 1'b1)
		op(0, 16'hFFFF, 0, 0, 0, 8'h00);
		prog_mode = 1;
		op(1, 16'h0010, d, 0, 0, 0);
		op(0, 16'h0010, 0, 0, 0, d);
		prog_mode = 0;
		op(1, 16'h3FFF, 8'h27, 0, 1, 0);
		prog_mode = 1;
		op(1, 16'h3FFF, 8'hFF, 0, 0, 0);
		op(1, 16'h3FFF, 8'h27, 0, 1, 0);
		op(2, 16'h1FC0, 0, 0, 0, 0);
		op(0, 16'hFFFF, 0, 0, 0, 8'h20);
		op(1, 16'h3FFF, 8'h27, 0, 0, 0);
		wd_exp = 0;
		rst();
		`CHK(boot_from_flash, 1'b1)
		`CHK(watchdog_enabled, 1'b0)
		halt_chk(0);
		op(0, 16'h0010, 0, 0, 0, 8'hFF);
		op(0, 16'hFFFF, 0, 0, 0, 8'h27);
		op(1, 16'h0020, d, 0, 1, 0);
		op(2, 16'h0000, 0, 0, 1, 0);
		op(1, 16'h0020, d, 1, 0, 0);
		op(2, 16'h1FC0, 0, 1, 0, 0);
		op(3, 16'h0000, 0, 0, 0, 0);
		wd_exp = 1;
		rst();
		op(0, 16'hFFFF, 0, 0, 0, 8'h00);
		halt_chk(1);
		`CHK(watchdog_enabled, 1'b1)
		repeat (3) @(posedge mclk);
		tally_and_finish();
	end
endmodule // testbench
bind flash_option_security opt_sva opt_sva_i (.*);
`default_nettype wire
